// ---- core/debug_local_regs.sv ----
// Debug module's own registers reached through the data window
`include "debug_access_regs.svh"
`default_nettype none
module debug_local_regs #(
    parameter int         DEBUG_PORT_COUNT  = 1,
    parameter bit         USE_CONSOLE       = 1,
    parameter bit         USE_CROSS_TRIGGER = 1,
    parameter bit         REG_ACCESS        = 1,
    parameter logic [7:0] SIGNATURE         = 8'h5A, // Arbitrary value
    parameter logic [7:0] VERSION           = 8'h11  // Arbitrary value
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // Access request
    input  wire logic        i_access,
    input  wire logic        i_write,
    input  wire logic [7:0]  i_command,
    input  wire logic [8:0]  i_length,
    input  wire logic [31:0] i_wdata,
    // Trigger state in
    input  wire logic [23:0] i_trigger_status,
    // Results
    output logic [31:0]      o_rdata,
    output logic [31:0]      o_processor_select,
    output logic [9:0]       o_ext_trigger_control,
    output logic             o_ext_trigger_strobe,
    output logic [15:0]      o_trigger_control,
    output logic             o_trigger_strobe
);
    logic [34:0] config_w; // Extended configuration word

    // Assemble configuration words
    always_comb begin
        config_w = 35'h0;
        config_w[31:24] = SIGNATURE;
        config_w[`CFG_RES_BIT] = 1'h1;
        config_w[`CFG_EXT_BIT] = 1'h1;
        config_w[`CFG_CONSOLE_BIT] = USE_CONSOLE;
        config_w[20:16] = `CFG_CHAR_WIDTH;
        config_w[15:8] = DEBUG_PORT_COUNT[7:0];
        config_w[7:0] = VERSION;
        config_w[`EXT_CROSS_BIT] = USE_CROSS_TRIGGER;
        config_w[`EXT_ACCESS_BIT] = REG_ACCESS;
    end

    // Read answers, registered
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_rdata <= 32'h0;
        end else if (i_access && !i_write) begin
            o_rdata <= 32'h0;
            if (i_command == `CMD_CONFIG && i_length == `LEN_CONFIG) begin
                o_rdata <= config_w[31:0];
            end else if (i_command == `CMD_CONFIG && i_length == `LEN_CONFIG_EXT) begin
                o_rdata <= config_w[34:3];
            end else if (USE_CROSS_TRIGGER && i_command == `CMD_TRIG_STATUS) begin
                o_rdata <= {8'h0, i_trigger_status};
            end
        end
    end

    // Write-only registers; configuration ignores writes
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_processor_select    <= 32'h0;
            o_ext_trigger_control <= 10'h0;
            o_ext_trigger_strobe  <= 1'h0;
            o_trigger_control     <= 16'h0;
            o_trigger_strobe      <= 1'h0;
        end else begin
            o_ext_trigger_strobe <= 1'h0;
            o_trigger_strobe     <= 1'h0;
            if (i_access && i_write) begin
                // Select width follows the length field
                if (i_command == `CMD_PROC_SELECT && i_length >= `LEN_SELECT_MIN
                    && i_length <= `LEN_SELECT_MAX) begin
                    o_processor_select <= i_wdata >> (5'(`LEN_SELECT_MAX - i_length));
                end
                if (USE_CROSS_TRIGGER && i_command == `CMD_EXT_TRIG_CTRL) begin
                    o_ext_trigger_control <= i_wdata[9:0];
                    o_ext_trigger_strobe  <= 1'h1;
                end
                if (USE_CROSS_TRIGGER && i_command == `CMD_TRIG_CTRL) begin
                    o_trigger_control <= i_wdata[15:0];
                    o_trigger_strobe  <= 1'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/debug_register_access.sv ----
// Console control, access lock and debug register access over the register bus
// Function
// - Control bit 2 clears external break
// - Control bit 1 empties receive FIFO
// - Control bit 0 empties transmit FIFO
// - Status bit 0 shows JTAG lock
// - Reading control register returns zero, OKAY
// - Control writes ignored until unlocked
// - Bits 19-18 select lock type
// - Bit 17 selects processor or module
// - Command and length fields of control
// - Data window moves data, locked ignored
// - Key unlocks; other values relock
// - Interrupt on transmit empty or receive data
// - Configuration read with command 0x0C
// - Configuration word field layout
// - Extended configuration, 35 bits, options
// - Processor select written with 0x0D
// - External trigger control with 0x40
// - Trigger control with 0x46
// - Trigger status read with 0x42
// - Access registers exist only when enabled
// - Offsets 0x10, 0x14, 0x18
`include "debug_access_regs.svh"
`default_nettype none
module debug_register_access #(
    parameter int         DEBUG_PORT_COUNT  = 1,
    parameter bit         USE_CONSOLE       = 1,
    parameter bit         USE_CROSS_TRIGGER = 1,
    parameter bit         REG_ACCESS        = 1,
    parameter logic [7:0] SIGNATURE         = 8'h5A, // Arbitrary value
    parameter logic [7:0] VERSION           = 8'h11  // Arbitrary value
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // Register bus write address
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    // Register bus write data
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    // Register bus write response
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    // Register bus read address
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    // Register bus read data
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    // Console side
    input  wire logic        i_tx_fifo_empty,
    input  wire logic        i_rx_fifo_valid,
    output logic             o_tx_fifo_clear,
    output logic             o_rx_fifo_clear,
    output logic             o_clear_external_break,
    output logic             o_interrupt,
    // Lock arbitration with JTAG side
    input  wire logic        i_jtag_lock_held,
    output logic             o_bus_lock_held,
    // Processor debug register port
    output logic             o_proc_request,
    output logic             o_proc_write,
    output logic [7:0]       o_proc_command,
    output logic [8:0]       o_proc_length,
    output logic [31:0]      o_proc_wdata,
    input  wire logic [31:0] i_proc_rdata,
    input  wire logic        i_proc_done,
    // Debug module registers out
    input  wire logic [23:0] i_trigger_status,
    output logic [31:0]      o_processor_select,
    output logic [9:0]       o_ext_trigger_control,
    output logic             o_ext_trigger_strobe,
    output logic [15:0]      o_trigger_control,
    output logic             o_trigger_strobe
);
    // Bus handshake state
    logic                          wr_fire;       // Write taken this cycle
    logic                          rd_fire;       // Read taken this cycle
    logic                          full_word;     // All byte lanes written
    logic                          wr_window;     // Full-word window write
    logic                          rd_window;     // Window read taken
    debug_access_pkg::rd_state_t   rd_state_q;    // Read channel state
    // Console state
    logic                          int_enable_q;  // Interrupt enable
    logic                          tx_empty_q;    // Previous transmit empty
    // Access lock state
    logic                          jtag_lock_s;   // Synchronised JTAG lock
    logic                          unlocked_q;    // Key written
    logic                          sw_lock_q;     // Bus side holds lock
    logic [19:0]                   ctrl_q;        // Command control
    debug_access_pkg::lock_type_t  lock_type;     // Decoded lock type
    logic                          granted;       // Access may proceed
    // Local register port
    logic                          local_access;  // Access pulse
    logic [31:0]                   local_rdata;   // Local read answer

    // Decode a register offset when access logic is built
    function automatic logic access_reg(input logic [7:0] a, input logic [7:0] ofs);
        access_reg = REG_ACCESS && (a == ofs);
    endfunction

    // Synchronise the JTAG lock flag
    level_sync u_lock_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_level (i_jtag_lock_held),
        .o_level (jtag_lock_s)
    );

    // Own debug registers
    debug_local_regs #(
        .DEBUG_PORT_COUNT  (DEBUG_PORT_COUNT),
        .USE_CONSOLE       (USE_CONSOLE),
        .USE_CROSS_TRIGGER (USE_CROSS_TRIGGER),
        .REG_ACCESS        (REG_ACCESS),
        .SIGNATURE         (SIGNATURE),
        .VERSION           (VERSION)
    ) u_local (
        .i_clock               (i_clock),
        .i_rst                 (i_rst),
        .i_access              (local_access),
        .i_write               (wr_fire),
        .i_command             (ctrl_q[`CTRL_CMD_HI:`CTRL_CMD_LO]),
        .i_length              (ctrl_q[`CTRL_LEN_HI:`CTRL_LEN_LO]),
        .i_wdata               (i_s_axi_wdata),
        .i_trigger_status      (i_trigger_status),
        .o_rdata               (local_rdata),
        .o_processor_select    (o_processor_select),
        .o_ext_trigger_control (o_ext_trigger_control),
        .o_ext_trigger_strobe  (o_ext_trigger_strobe),
        .o_trigger_control     (o_trigger_control),
        .o_trigger_strobe      (o_trigger_strobe)
    );

    // Handshakes: write wins a tie with read
    always_comb begin
        o_s_axi_awready = !o_s_axi_bvalid && (rd_state_q == debug_access_pkg::RD_IDLE)
                          && i_s_axi_awvalid && i_s_axi_wvalid;
        o_s_axi_wready  = o_s_axi_awready;
        wr_fire         = o_s_axi_awready;
        o_s_axi_arready = !o_s_axi_rvalid && (rd_state_q == debug_access_pkg::RD_IDLE)
                          && !wr_fire;
        rd_fire         = o_s_axi_arready && i_s_axi_arvalid;
        full_word       = (i_s_axi_wstrb == 4'hF);
        wr_window       = wr_fire && full_word && access_reg(i_s_axi_awaddr, `OFS_DATA_WINDOW);
        rd_window       = rd_fire && access_reg(i_s_axi_araddr, `OFS_DATA_WINDOW);
    end

    // Lock decode and grant
    always_comb begin
        lock_type = debug_access_pkg::lock_type_t'(ctrl_q[`CTRL_LOCK_HI:`CTRL_LOCK_LO]);
        // Force takes the lock even from JTAG
        granted   = unlocked_q && (lock_type == debug_access_pkg::LOCK_FORCE
                    || !jtag_lock_s);
    end

    // Pulse to the local registers for a granted window access
    always_comb begin
        local_access = ctrl_q[`CTRL_TARGET_BIT] && granted && (wr_window || rd_window);
    end

    // Unlock key register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            unlocked_q <= 1'h0;
        end else if (wr_fire && full_word && access_reg(i_s_axi_awaddr, `OFS_UNLOCK_KEY)) begin
            // Only the key opens; anything else closes
            unlocked_q <= (i_s_axi_wdata[15:0] == `UNLOCK_KEY);
        end
    end

    // Command control register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_q <= `CTRL_RESET;
        end else if (wr_fire && full_word && unlocked_q
                     && access_reg(i_s_axi_awaddr, `OFS_COMMAND_CONTROL)) begin
            ctrl_q <= i_s_axi_wdata[19:0];
        end
    end

    // Bus side lock ownership
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sw_lock_q <= 1'h0;
        end else if (wr_fire && full_word && unlocked_q
                     && access_reg(i_s_axi_awaddr, `OFS_COMMAND_CONTROL)
                     && i_s_axi_wdata[`CTRL_LOCK_HI:`CTRL_LOCK_LO] == 2'h0) begin
            // Release aborts any atomic sequence
            sw_lock_q <= 1'h0;
        end else if (granted && lock_type[1] && (wr_window || rd_window)) begin
            // Lock taken with the first keep or force window access and kept
            sw_lock_q <= 1'h1;
        end
    end

    // Lock shown to JTAG side, also while any window read is in progress
    always_comb begin
        o_bus_lock_held = sw_lock_q || (rd_state_q != debug_access_pkg::RD_IDLE);
    end

    // Processor debug request
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_proc_request <= 1'h0;
            o_proc_write   <= 1'h0;
            o_proc_command <= 8'h0;
            o_proc_length  <= 9'h0;
            o_proc_wdata   <= 32'h0;
        end else begin
            o_proc_request <= 1'h0;
            if (!ctrl_q[`CTRL_TARGET_BIT] && granted && (wr_window || rd_window)) begin
                o_proc_request <= 1'h1;
                o_proc_write   <= wr_window;
                o_proc_command <= ctrl_q[`CTRL_CMD_HI:`CTRL_CMD_LO];
                o_proc_length  <= ctrl_q[`CTRL_LEN_HI:`CTRL_LEN_LO];
                o_proc_wdata   <= i_s_axi_wdata;
            end
        end
    end

    // Write response channel
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_s_axi_bvalid <= 1'h0;
            o_s_axi_bresp  <= debug_access_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            o_s_axi_bvalid <= 1'h1;
            // Unmapped offsets get an error
            if (i_s_axi_awaddr == `OFS_CONSOLE_CONTROL
                || access_reg(i_s_axi_awaddr, `OFS_COMMAND_CONTROL)
                || access_reg(i_s_axi_awaddr, `OFS_DATA_WINDOW)
                || access_reg(i_s_axi_awaddr, `OFS_UNLOCK_KEY)) begin
                o_s_axi_bresp <= debug_access_pkg::RESP_OKAY;
            end else begin
                o_s_axi_bresp <= debug_access_pkg::RESP_SLVERR;
            end
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'h0;
        end
    end

    // Read state: window reads wait for their target
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rd_state_q <= debug_access_pkg::RD_IDLE;
        end else begin
            case (rd_state_q)
                debug_access_pkg::RD_IDLE: begin
                    if (rd_window && granted) begin
                        rd_state_q <= ctrl_q[`CTRL_TARGET_BIT] ? debug_access_pkg::RD_LOCAL
                                                               : debug_access_pkg::RD_PROC;
                    end
                end
                debug_access_pkg::RD_LOCAL: begin
                    rd_state_q <= debug_access_pkg::RD_IDLE;
                end
                debug_access_pkg::RD_PROC: begin
                    if (i_proc_done) begin
                        rd_state_q <= debug_access_pkg::RD_IDLE;
                    end
                end
                default: begin
                    rd_state_q <= debug_access_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // Read data channel
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_s_axi_rvalid <= 1'h0;
            o_s_axi_rdata  <= 32'h0;
            o_s_axi_rresp  <= debug_access_pkg::RESP_OKAY;
        end else if (rd_state_q == debug_access_pkg::RD_LOCAL) begin
            o_s_axi_rvalid <= 1'h1;
            o_s_axi_rdata  <= local_rdata;
        end else if (rd_state_q == debug_access_pkg::RD_PROC && i_proc_done) begin
            o_s_axi_rvalid <= 1'h1;
            o_s_axi_rdata  <= i_proc_rdata;
        end else if (rd_fire) begin
            o_s_axi_rdata <= 32'h0;
            o_s_axi_rresp <= debug_access_pkg::RESP_OKAY;
            if (access_reg(i_s_axi_araddr, `OFS_LOCK_STATUS)) begin
                // Shared offset reads status; control itself reads zero
                o_s_axi_rdata[`LS_LOCK_BIT] <= jtag_lock_s;
                o_s_axi_rvalid <= 1'h1;
            end else if (rd_window) begin
                // Locked window answers zero now
                o_s_axi_rvalid <= !granted;
            end else if (access_reg(i_s_axi_araddr, `OFS_UNLOCK_KEY)
                         || i_s_axi_araddr == `OFS_CONSOLE_CONTROL) begin
                o_s_axi_rvalid <= 1'h1;
            end else begin
                o_s_axi_rvalid <= 1'h1;
                o_s_axi_rresp  <= debug_access_pkg::RESP_SLVERR;
            end
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'h0;
        end
    end

    // Console control: enable and one-cycle clear pulses
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            int_enable_q           <= 1'h0;
            o_clear_external_break <= 1'h0;
            o_rx_fifo_clear        <= `CC_CLEAR_RESET;
            o_tx_fifo_clear        <= `CC_CLEAR_RESET;
        end else begin
            o_clear_external_break <= 1'h0;
            o_rx_fifo_clear        <= 1'h0;
            o_tx_fifo_clear        <= 1'h0;
            if (wr_fire && full_word && i_s_axi_awaddr == `OFS_CONSOLE_CONTROL) begin
                int_enable_q           <= i_s_axi_wdata[`CC_INT_ENABLE_BIT];
                o_clear_external_break <= i_s_axi_wdata[`CC_CLEAR_BREAK_BIT];
                o_rx_fifo_clear        <= i_s_axi_wdata[`CC_CLEAR_RX_BIT];
                o_tx_fifo_clear        <= i_s_axi_wdata[`CC_CLEAR_TX_BIT];
            end
        end
    end

    // Previous transmit empty for edge detect
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            tx_empty_q <= 1'h1;
        end else begin
            tx_empty_q <= i_tx_fifo_empty;
        end
    end

    // Interrupt on transmit going empty or receive holding data
    always_comb begin
        o_interrupt = int_enable_q
                      && ((i_tx_fifo_empty && !tx_empty_q) || i_rx_fifo_valid);
    end
endmodule
`default_nettype wire

// ---- core/level_sync.sv ----
// Two-stage synchroniser for a level from another clock domain
`default_nettype none
module level_sync (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // Level in and out
    input  wire logic i_level,
    output logic      o_level
);
    logic meta_q; // First stage, read only by second
    // Two flops in series
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_q  <= 1'h0;
            o_level <= 1'h0;
        end else begin
            meta_q  <= i_level;
            o_level <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- shared/debug_access_pkg.sv ----
// Types shared by the debug register block
`default_nettype none
package debug_access_pkg;
    // Lock type field codes
    typedef enum logic [1:0] {
        LOCK_RELEASE = 2'h0,
        LOCK_ONCE    = 2'h1,
        LOCK_KEEP    = 2'h2,
        LOCK_FORCE   = 2'h3
    } lock_type_t;
    // Bus response codes
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'h0,
        RESP_SLVERR = 2'h2
    } resp_t;
    // Read channel states
    typedef enum logic [1:0] {
        RD_IDLE   = 2'h0,
        RD_LOCAL  = 2'h1,
        RD_PROC   = 2'h2
    } rd_state_t;
endpackage
`default_nettype wire

// ---- shared/debug_access_regs.svh ----
// Offsets, field positions, reset values and codes of the debug register block
`ifndef DEBUG_ACCESS_REGS_SVH
`define DEBUG_ACCESS_REGS_SVH
// Bus offsets
`define OFS_CONSOLE_CONTROL 8'h0C
`define OFS_LOCK_STATUS     8'h10
`define OFS_COMMAND_CONTROL 8'h10
`define OFS_DATA_WINDOW     8'h14
`define OFS_UNLOCK_KEY      8'h18
// Console control fields
`define CC_INT_ENABLE_BIT   4
`define CC_CLEAR_BREAK_BIT  2
`define CC_CLEAR_RX_BIT     1
`define CC_CLEAR_TX_BIT     0
`define CC_CLEAR_RESET      1'h1
// Lock status field
`define LS_LOCK_BIT         0
// Command control fields
`define CTRL_LOCK_HI        19
`define CTRL_LOCK_LO        18
`define CTRL_TARGET_BIT     17
`define CTRL_CMD_HI         16
`define CTRL_CMD_LO         9
`define CTRL_LEN_HI         8
`define CTRL_LEN_LO         0
`define CTRL_RESET          20'h00000
// Unlock key
`define UNLOCK_KEY          16'hEBAB
// Debug module commands
`define CMD_CONFIG          8'h0C
`define CMD_PROC_SELECT     8'h0D
`define CMD_EXT_TRIG_CTRL   8'h40
`define CMD_TRIG_STATUS     8'h42
`define CMD_TRIG_CTRL       8'h46
// Register lengths minus one
`define LEN_CONFIG          9'h01F
`define LEN_CONFIG_EXT      9'h022
`define LEN_SELECT_MIN      9'h007
`define LEN_SELECT_MAX      9'h01F
`define LEN_EXT_TRIG        9'h009
`define LEN_TRIG_CTRL       9'h00F
`define LEN_TRIG_STATUS     9'h017
// Configuration fields
`define CFG_RES_BIT         23
`define CFG_EXT_BIT         22
`define CFG_CONSOLE_BIT     21
`define CFG_CHAR_WIDTH      5'h07
`define EXT_CROSS_BIT       34
`define EXT_ACCESS_BIT      33
`endif

// ---- test/debug_access_properties.sv ----
// Port-level checks of the debug register block
`default_nettype none
module debug_access_properties (
    input wire logic        i_clock, i_rst, i_s_axi_awvalid, o_s_axi_awready, i_s_axi_arvalid,
    input wire logic        o_s_axi_arready, o_s_axi_bvalid, o_s_axi_rvalid, i_rx_fifo_valid,
    input wire logic        i_tx_fifo_empty, o_interrupt, o_proc_request, o_clear_external_break,
    input wire logic        o_rx_fifo_clear, o_tx_fifo_clear,
    input wire logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr,
    input wire logic [31:0] i_s_axi_wdata, o_s_axi_rdata,
    input wire logic [3:0]  i_s_axi_wstrb,
    input wire logic [1:0]  o_s_axi_bresp, o_s_axi_rresp
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Full-word write or a read taken at one offset
    sequence s_wr(logic [7:0] a);
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_awaddr == a && i_s_axi_wstrb == 4'hF;
    endsequence
    sequence s_rd(logic [7:0] a);
        i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == a;
    endsequence
    a_break_clear: assert property (
        s_wr(8'h0C) ##0 i_s_axi_wdata[2] |=> o_clear_external_break) else $error("no break clear");
    a_rx_clear: assert property (
        s_wr(8'h0C) ##0 i_s_axi_wdata[1] |=> o_rx_fifo_clear) else $error("no rx clear");
    a_tx_clear: assert property (
        s_wr(8'h0C) ##0 i_s_axi_wdata[0] |=> o_tx_fifo_clear) else $error("no tx clear");
    a_status_upper_zero: assert property (
        s_rd(8'h10) |=> o_s_axi_rvalid && o_s_axi_rresp == 2'h0 && o_s_axi_rdata[31:1] == 31'h0)
        else $error("bad status read");
    a_unmapped_read: assert property (
        s_rd(8'h00) |=> o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 32'h0) else $error("bad read");
    a_unmapped_write: assert property (
        s_wr(8'h04) |=> o_s_axi_bvalid && o_s_axi_bresp == 2'h2) else $error("bad write resp");
    a_irq_has_cause: assert property (
        o_interrupt |-> i_rx_fifo_valid || $rose(i_tx_fifo_empty)) else $error("stray irq");
    a_request_cause: assert property (o_proc_request |-> $past(i_s_axi_araddr == 8'h14 &&
        i_s_axi_arvalid && o_s_axi_arready || o_s_axi_awready && i_s_axi_awaddr == 8'h14))
        else $error("stray request");
endmodule
`default_nettype wire

// ---- test/debug_proc_model.sv ----
// Processor debug register port that answers window reads after a delay
`default_nettype none
module debug_proc_model (
    input  wire logic   i_clock,
    input  wire logic   i_request,
    output logic        o_done = 0,
    output logic [31:0] o_rdata = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // Done and data four cycles after a request
    always @(posedge i_clock) begin
        cnt <= i_request ? 3 : (cnt > 0 ? cnt - 1 : 0);
        o_done <= cnt == 1;
        o_rdata <= cnt == 1 ? 32'h3C5A96E1 : ~o_rdata;
    end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the debug register block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] SIG = 8'h5A; // Arbitrary value
    localparam logic [7:0] VER = 8'h11; // Arbitrary value
    logic i_clock = 0, i_rst = 1, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_arvalid = 0;
    logic i_tx_fifo_empty = 0, i_rx_fifo_valid = 0, i_jtag_lock_held = 0, i_proc_done;
    logic i_s_axi_bready = 1, i_s_axi_rready = 1, o_s_axi_awready, o_s_axi_wready;
    logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_tx_fifo_clear, o_rx_fifo_clear;
    logic o_clear_external_break, o_interrupt, o_bus_lock_held, o_proc_request, o_proc_write;
    logic o_ext_trigger_strobe, o_trigger_strobe;
    logic [3:0] i_s_axi_wstrb = 4'hF;
    logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00, o_proc_command;
    logic [31:0] i_s_axi_wdata = 0, i_proc_rdata, o_s_axi_rdata, o_proc_wdata, o_processor_select;
    logic [31:0] rd_q;
    logic [23:0] i_trigger_status = 24'hA5C3F0;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp_q;
    logic [8:0] o_proc_length;
    logic [9:0] o_ext_trigger_control;
    logic [15:0] o_trigger_control;
    int num_errors = 0, checks_done = 0;
    debug_register_access #(.SIGNATURE(SIG), .VERSION(VER)) dut_u (.*);
    debug_proc_model proc_u (.i_clock(i_clock), .i_request(o_proc_request),
        .o_done(i_proc_done), .o_rdata(i_proc_rdata));
    always #5 i_clock = ~i_clock;
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1;
        i_s_axi_wvalid <= 1;
        do @(posedge i_clock); while (!o_s_axi_awready && ++n < 50);
        i_s_axi_awvalid <= 0;
        i_s_axi_wvalid <= 0;
        do @(posedge i_clock); while (!o_s_axi_bvalid && ++n < 50);
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1;
        do @(posedge i_clock); while (!o_s_axi_arready && ++n < 50);
        i_s_axi_arvalid <= 0;
        do @(posedge i_clock); while (!o_s_axi_rvalid && ++n < 50);
        rd_q = o_s_axi_rdata;
        resp_q = o_s_axi_rresp;
        tmo(n);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge i_clock);
        chk("tx clear", 1, o_tx_fifo_clear);
        chk("rx clear", 1, o_rx_fifo_clear);
        i_rst <= 0;
        rd(8'h10);
        chk("lock free", 0, rd_q);
        i_jtag_lock_held <= 1;
        repeat (4) @(posedge i_clock);
        rd(8'h10);
        chk("lock held", 1, rd_q);
        i_jtag_lock_held <= 0;
        rd(8'h00);
        chk("unmapped", 2, resp_q);
        wr(8'h04, 0);
        wr(8'h10, 32'h6181F);
        rd(8'h14);
        chk("locked data", 0, rd_q);
        wr(8'h18, 32'hEBAB);
        wr(8'h10, 32'h6181F);
        rd(8'h14);
        chk("config", {SIG, 8'hE7, 8'h01, VER}, rd_q);
        wr(8'h10, 32'h61822);
        rd(8'h14);
        chk("ext options", 2'h3, rd_q[31:30]);
        wr(8'h10, 32'h68417);
        rd(8'h14);
        chk("trig status", 32'hA5C3F0, rd_q);
        wr(8'h10, 32'h68009);
        wr(8'h14, 32'h3FF);
        chk("ext trig", 10'h3FF, o_ext_trigger_control);
        wr(8'h10, 32'h68C0F);
        wr(8'h14, 32'hBEEF);
        chk("trig ctrl", 16'hBEEF, o_trigger_control);
        wr(8'h10, 32'h61A07);
        wr(8'h14, 32'hA5000000);
        chk("select", 32'hA5, o_processor_select);
        wr(8'h10, 32'h4021F);
        rd(8'h14);
        chk("proc data", 32'h3C5A96E1, rd_q);
        wr(8'h18, 32'h1234);
        rd(8'h14);
        chk("relocked", 0, rd_q);
        wr(8'h0C, 32'h17);
        i_rx_fifo_valid <= 1;
        @(posedge i_clock);
        chk("irq", 1, o_interrupt);
        wr(8'h0C, 32'h0);
        chk("irq off", 0, o_interrupt);
        report_and_stop();
    end
endmodule
bind debug_register_access debug_access_properties chk_u (.*);
`default_nettype wire
